//--- hw/cisd_pkg.sv
// Package of encodings, widths and phase constants for the four-instruction decoder
package cisd_pkg;
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 13;
   // Store accumulator to file: 00 0000 1fff ffff
   localparam logic [6:0] STORE_PREFIX = 7'h01;
   localparam int STORE_PREFIX_LSB = 7;
   // No-operation: 00 0000 0xx0 0000, don't-care bits masked off
   localparam logic [13:0] NOP_MASK = 14'h3f9f;
   localparam logic [13:0] NOP_CODE = 14'h0000;
   // Return from interrupt and legacy option load
   localparam logic [13:0] RETI_CODE = 14'h0009;
   localparam logic [13:0] OPTLOAD_CODE = 14'h0062;
   // Global interrupt enable position in the interrupt control register
   localparam int GIE_BIT = 7;
   // File address of the option configuration register in ordinary addressing
   localparam logic [6:0] OPTION_ADDR = 7'h01;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [7:0] IRQCTL_RESET = 8'h00;

   // Quarter phases, Gray coded
   typedef enum logic [1:0]
   {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b11,
      PH_Q4 = 2'b10
   } cisd_phase_t;

   // Decoded instruction class
   typedef enum logic [2:0]
   {
      OP_OTHER = 3'h0,
      OP_STORE = 3'h1,
      OP_NOP = 3'h2,
      OP_RETI = 3'h3,
      OP_OPTLOAD = 3'h4
   } cisd_op_t;
endpackage : cisd_pkg

//--- hw/cisd_phase_gen.sv
// Quarter-phase sequencer for the instruction cycle
`timescale 1ns/1ns
module cisd_phase_gen
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   output cisd_pkg::cisd_phase_t phase
);
   import cisd_pkg::*;

   typedef struct packed
   {
      cisd_phase_t phase;
   } cisd_pg_state_t;

   cisd_pg_state_t state_ff;
   cisd_pg_state_t nxt_state;

   // Step Q1, Q2, Q3, Q4 and wrap
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff.phase)
         PH_Q1: nxt_state.phase = PH_Q2;
         PH_Q2: nxt_state.phase = PH_Q3;
         PH_Q3: nxt_state.phase = PH_Q4;
         default: nxt_state.phase = PH_Q1;
      endcase
   end

   // Phase register, frozen while clkEn is low
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= '{phase: PH_Q1};
      end
      else if (clkEn)
      begin
         state_ff <= nxt_state;
      end
   end

   assign phase = state_ff.phase;
endmodule : cisd_phase_gen

//--- hw/cisd_decode.sv
// Decode and execute of store-to-file, no-op, return-from-interrupt and option load
`timescale 1ns/1ns
// Behaviour
// RULE1: Store accumulator to addressed file, no flags
// RULE2: No-op changes nothing for one cycle
// RULE3: Return from interrupt pops stack into PC
// RULE4: Return sets global enable, bit seven
// RULE5: Return: two cycles, Q3 enable, Q4 pop
// RULE6: Legacy option load from accumulator, no flags
// RULE7: Option register also reachable by file address
// RULE8: Four quarters: decode, read, process, write
module cisd_decode
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [cisd_pkg::INSTR_W-1:0] instrWord,
   input wire logic [cisd_pkg::DATA_W-1:0] accumValue,
   input wire logic [cisd_pkg::PC_W-1:0] stackTopValue,
   input wire logic fileWrEn,
   input wire logic [cisd_pkg::FADDR_W-1:0] fileWrAddr,
   input wire logic [cisd_pkg::DATA_W-1:0] fileWrData,
   input wire logic irqAccepted,
   output logic [cisd_pkg::FADDR_W-1:0] fileAddr,
   output logic [cisd_pkg::DATA_W-1:0] fileData,
   output logic fileWrite,
   output logic stackPop,
   output logic pcLoad,
   output logic [cisd_pkg::PC_W-1:0] pcValue,
   output logic [cisd_pkg::DATA_W-1:0] irqControlRegister,
   output logic globalIrqEnable,
   output logic [cisd_pkg::DATA_W-1:0] optionRegister,
   output logic flagsWrite,
   output logic fetchStall,
   output logic [1:0] quarter
);
   import cisd_pkg::*;

   // Elaboration check on the widths that the encodings assume
   if (INSTR_W != 14 || FADDR_W != 7 || GIE_BIT >= DATA_W)
   begin : g_bad_width
      $error("cisd_decode: unsupported width settings");
   end

   // Classify one instruction word
   function automatic cisd_op_t classify(input logic [INSTR_W-1:0] w);
      cisd_op_t op;
      op = OP_OTHER;
      if (w[INSTR_W-1:STORE_PREFIX_LSB] == STORE_PREFIX)
         op = OP_STORE;
      else if ((w & NOP_MASK) == NOP_CODE)
         op = OP_NOP;
      else if (w == RETI_CODE)
         op = OP_RETI;
      else if (w == OPTLOAD_CODE)
         op = OP_OPTLOAD;
      return op;
   endfunction : classify

   typedef struct packed
   {
      cisd_op_t op;
      logic secondCycle;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] operand;
      logic [FADDR_W-1:0] fileAddr;
      logic [DATA_W-1:0] fileData;
      logic fileWrite;
      logic stackPop;
      logic pcLoad;
      logic [PC_W-1:0] pcValue;
      logic [DATA_W-1:0] irqCtl;
      logic [DATA_W-1:0] option;
      logic fetchStall;
   } cisd_state_t;

   cisd_state_t state_ff;
   cisd_state_t nxt_state;
   cisd_phase_t phase;

   // ==========================================================
   // Quarter phase sequencer
   cisd_phase_gen u_phase
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .phase(phase)
   );

   // ==========================================================
   // Per-quarter decode and execute
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.fileWrite = 1'b0;
      nxt_state.stackPop = 1'b0;
      nxt_state.pcLoad = 1'b0;
      // Interrupt acceptance clears the global enable
      if (irqAccepted)
         nxt_state.irqCtl[GIE_BIT] = 1'b0;
      // Ordinary file writes reach the option register only, not the control register
      if (fileWrEn && fileWrAddr == OPTION_ADDR)
         nxt_state.option = fileWrData; // RULE7
      case (phase)
         PH_Q1:
         begin
            // Second cycle of a return is a no-op slot
            if (state_ff.op == OP_RETI && !state_ff.secondCycle)
            begin
               nxt_state.secondCycle = 1'b1; // RULE5
               nxt_state.op = OP_NOP;
            end
            else
            begin
               nxt_state.secondCycle = 1'b0;
               nxt_state.op = classify(instrWord); // RULE8
               nxt_state.addr = instrWord[FADDR_W-1:0];
            end
         end
         PH_Q2:
         begin
            // Operand read
            if (state_ff.op == OP_STORE || state_ff.op == OP_OPTLOAD)
               nxt_state.operand = accumValue; // RULE8
         end
         PH_Q3:
         begin
            // Processing; return sets the global enable here
            if (state_ff.op == OP_RETI && !state_ff.secondCycle)
               nxt_state.irqCtl[GIE_BIT] = 1'b1; // RULE4
            nxt_state.fetchStall = (state_ff.op == OP_RETI) && !state_ff.secondCycle;
         end
         default:
         begin
            // Q4: result write or stack action
            case (state_ff.op)
               OP_STORE:
               begin
                  nxt_state.fileAddr = state_ff.addr; // RULE1
                  nxt_state.fileData = state_ff.operand;
                  nxt_state.fileWrite = 1'b1;
                  if (state_ff.addr == OPTION_ADDR)
                     nxt_state.option = state_ff.operand; // RULE7
               end
               OP_OPTLOAD:
                  nxt_state.option = state_ff.operand; // RULE6
               OP_RETI:
               begin
                  if (!state_ff.secondCycle)
                  begin
                     nxt_state.stackPop = 1'b1; // RULE3
                     nxt_state.pcLoad = 1'b1;
                     nxt_state.pcValue = stackTopValue;
                  end
               end
               default:
                  nxt_state.fileWrite = 1'b0; // RULE2
            endcase
         end
      endcase
   end

   // ==========================================================
   // State register, frozen while clkEn is low
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= '{op: OP_NOP, secondCycle: 1'b0, addr: '0, operand: '0,
                       fileAddr: '0, fileData: '0, fileWrite: 1'b0, stackPop: 1'b0,
                       pcLoad: 1'b0, pcValue: '0, irqCtl: IRQCTL_RESET,
                       option: OPTION_RESET, fetchStall: 1'b0};
      end
      else if (clkEn)
      begin
         state_ff <= nxt_state;
      end
   end

   // Outputs straight from flip-flops; flags never written by these ops
   assign fileAddr = state_ff.fileAddr;
   assign fileData = state_ff.fileData;
   assign fileWrite = state_ff.fileWrite;
   assign stackPop = state_ff.stackPop;
   assign pcLoad = state_ff.pcLoad;
   assign pcValue = state_ff.pcValue;
   assign irqControlRegister = state_ff.irqCtl;
   assign globalIrqEnable = state_ff.irqCtl[GIE_BIT];
   assign optionRegister = state_ff.option;
   assign flagsWrite = state_ff.secondCycle & 1'b0; // RULE1 RULE6
   assign fetchStall = state_ff.fetchStall;
   assign quarter = phase;
endmodule : cisd_decode

//--- test/cisd_decode_props.sv
// Concurrent checks on the ports of the four-instruction decoder
`timescale 1ns/1ns
module cisd_decode_props
import cisd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [INSTR_W-1:0] instrWord,
   input wire logic [DATA_W-1:0] accumValue,
   input wire logic [PC_W-1:0] stackTopValue,
   input wire logic fileWrEn,
   input wire logic [FADDR_W-1:0] fileWrAddr,
   input wire logic [DATA_W-1:0] fileWrData,
   input wire logic [FADDR_W-1:0] fileAddr,
   input wire logic [DATA_W-1:0] fileData,
   input wire logic fileWrite,
   input wire logic stackPop,
   input wire logic pcLoad,
   input wire logic [PC_W-1:0] pcValue,
   input wire logic [DATA_W-1:0] irqControlRegister,
   input wire logic globalIrqEnable,
   input wire logic [DATA_W-1:0] optionRegister,
   input wire logic flagsWrite,
   input wire logic fetchStall,
   input wire logic [1:0] quarter
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========
   // Instruction results, counted from the edge that leaves Q1
   store_write_a: assert property (
      clkEn && !fetchStall && quarter == 2'b00 && instrWord[13:7] == STORE_PREFIX
      ##1 clkEn[*3]
      |=> fileWrite && fileAddr == $past(instrWord[6:0], 4) && fileData == $past(accumValue, 3))
      else $error("store result wrong");
   flags_kept_a: assert property (!flagsWrite)
      else $error("flags written");
   reti_enable_a: assert property (
      clkEn && !fetchStall && quarter == 2'b00 && instrWord == RETI_CODE ##1 clkEn[*2]
      |=> globalIrqEnable)
      else $error("enable not set in Q3");
   reti_pop_a: assert property (
      clkEn && !fetchStall && quarter == 2'b00 && instrWord == RETI_CODE ##1 clkEn[*3]
      |=> stackPop && pcLoad && pcValue == $past(stackTopValue))
      else $error("pop wrong");
   enable_bit_a: assert property (
      globalIrqEnable == irqControlRegister[GIE_BIT]
      && irqControlRegister[GIE_BIT-1:0] == $past(irqControlRegister[GIE_BIT-1:0]))
      else $error("enable not bit 7");
   option_load_a: assert property (
      clkEn && !fetchStall && quarter == 2'b00 && instrWord == OPTLOAD_CODE ##1 clkEn[*3]
      |=> optionRegister == $past(accumValue, 3))
      else $error("option load wrong");
   option_file_a: assert property (
      clkEn && fileWrEn && fileWrAddr == OPTION_ADDR |=> optionRegister == $past(fileWrData))
      else $error("option file write lost");
   quarter_step_a: assert property (clkEn && quarter == 2'b00 |=> quarter == 2'b01)
      else $error("quarter order wrong");
   pop_pulse_a: assert property (stackPop && clkEn |=> !stackPop)
      else $error("pop longer than a clock");
   // Main scenarios reached
   cover property (stackPop);
   cover property (fileWrite && fileAddr == OPTION_ADDR);
   cover property ($fell(globalIrqEnable));
   cover property (fetchStall);
endmodule : cisd_decode_props

bind cisd_decode cisd_decode_props cisd_decode_props_i (.sys_clk(sys_clk), .rst(rst),
   .clkEn(clkEn), .instrWord(instrWord), .accumValue(accumValue),
   .stackTopValue(stackTopValue), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
   .fileWrData(fileWrData), .fileAddr(fileAddr), .fileData(fileData), .fileWrite(fileWrite),
   .stackPop(stackPop), .pcLoad(pcLoad), .pcValue(pcValue),
   .irqControlRegister(irqControlRegister), .globalIrqEnable(globalIrqEnable),
   .optionRegister(optionRegister), .flagsWrite(flagsWrite), .fetchStall(fetchStall),
   .quarter(quarter));

//--- test/cisd_decode_tb_top.sv
// Table-driven testbench of the four-instruction decoder
`timescale 1ns/1ns
module cisd_decode_tb_top;
   import cisd_pkg::*;
   typedef struct {logic [13:0] ins; logic [7:0] w; logic [12:0] stack_top_value;
      logic wr; logic pop; logic [7:0] opt; logic global_irq_enable;} cisd_row_t;
   logic sys_clk = 0, rst = 1, clkEn = 1, irqAccepted = 0, fileWrEn = 0;
   logic [13:0] instrWord = 14'h0000;
   logic [7:0] accumValue = 8'h00, fileWrData = 8'h00, fileData, irqCtl, optionRegister;
   logic [12:0] stackTopValue = 13'h0000, pcValue;
   logic [6:0] fileWrAddr = 7'h00, fileAddr;
   logic fileWrite, stackPop, pcLoad, global_irq_enable, flagsWrite, fetchStall;
   logic [1:0] quarter, q;
   int num_errors = 0, comparisons = 0;
   cisd_row_t rows [7] = '{'{14'h0085, 8'haa, 13'h0, 1'h1, 1'h0, 8'hff, 1'h0},
      '{14'h0060, 8'h11, 13'h0, 1'h0, 1'h0, 8'hff, 1'h0},
      '{14'h0000, 8'h22, 13'h0, 1'h0, 1'h0, 8'hff, 1'h0},
      '{14'h0008, 8'h33, 13'h0, 1'h0, 1'h0, 8'hff, 1'h0},
      '{14'h0062, 8'h4f, 13'h0, 1'h0, 1'h0, 8'h4f, 1'h0},
      '{14'h0081, 8'h3c, 13'h0, 1'h1, 1'h0, 8'h3c, 1'h0},
      '{14'h0009, 8'h00, 13'h1234, 1'h0, 1'h1, 8'h3c, 1'h1}};
   always #4 sys_clk = ~sys_clk;
   cisd_decode cisd_decode_i (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
      .instrWord(instrWord), .accumValue(accumValue), .stackTopValue(stackTopValue),
      .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
      .irqAccepted(irqAccepted), .fileAddr(fileAddr), .fileData(fileData),
      .fileWrite(fileWrite), .stackPop(stackPop), .pcLoad(pcLoad), .pcValue(pcValue),
      .irqControlRegister(irqCtl), .globalIrqEnable(global_irq_enable), .optionRegister(optionRegister),
      .flagsWrite(flagsWrite), .fetchStall(fetchStall), .quarter(quarter));
   // ==========
   // Shared helpers
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   // Watchdog
   initial
   begin
      #20000;
      num_errors++;
      finish_test();
   end
   // ==========
   // Main sequence
   initial
   begin
      tick(12);
      chk(quarter, 2'b00);
      chk(optionRegister, 8'hff);
      chk(irqCtl, 8'h00);
      rst = 0;
      $display("reset test done");
      foreach (rows[i])
      begin
         instrWord = rows[i].ins;
         accumValue = rows[i].w;
         stackTopValue = rows[i].stack_top_value;
         tick(4);
         chk(fileWrite, rows[i].wr);
         if (rows[i].wr) chk({fileAddr, fileData}, {rows[i].ins[6:0], rows[i].w});
         chk({stackPop, pcLoad}, {2{rows[i].pop}});
         if (rows[i].pop) chk(pcValue, rows[i].stack_top_value);
         chk(optionRegister, rows[i].opt);
         chk(global_irq_enable, rows[i].global_irq_enable);
         chk(irqCtl, {rows[i].global_irq_enable, 7'h00});
         chk(fetchStall, rows[i].pop);
         chk(flagsWrite, 1'b0);
         instrWord = NOP_CODE;
         if (rows[i].pop) tick(4);
         if (rows[i].pop) chk({stackPop, fileWrite, fetchStall}, 3'h0);
         $display("row %0d done", i);
      end
      irqAccepted = 1;
      tick(1);
      irqAccepted = 0;
      chk(irqCtl, 8'h00);
      fileWrEn = 1;
      fileWrAddr = OPTION_ADDR;
      fileWrData = 8'h5a;
      tick(1);
      fileWrEn = 0;
      chk(optionRegister, 8'h5a);
      $display("irq and file write test done");
      clkEn = 0;
      q = quarter;
      tick(3);
      chk(quarter, q);
      clkEn = 1;
      rst = 1;
      tick(1);
      chk({quarter, optionRegister, irqCtl}, {2'b00, 8'hff, 8'h00});
      rst = 0;
      $display("freeze and reset test done");
      finish_test();
   end
endmodule : cisd_decode_tb_top
